/* rtl/plz_pkg.sv */
package plz_pkg;
   localparam int VAL_W = 21;
   localparam int PTS = 16;
   localparam int EXT_W = 23;
   localparam int DIV_W = 2 * EXT_W;
   localparam int CNT_W = 6;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_MIRROR = 2'h1;
   localparam logic [1:0] MODE_FULL = 2'h2;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [VAL_W-1:0] TBL_RST = 21'h000000;
   localparam logic [ADDR_W-1:0] OFS_MODE_CH1 = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_MODE_CH2 = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
   localparam logic [3:0] PAGE_TBL_CH1 = 4'h1;
   localparam logic [3:0] PAGE_TBL_CH2 = 4'h2;
   localparam int TBL_CH_BIT = 9;
   localparam int TBL_Y_BIT = 2;
   localparam int TBL_PT_LSB = 3;
   localparam int TBL_PT_MSB = 6;
   localparam int TBL_HOLE_BIT = 7;
   localparam logic [CNT_W-1:0] DIV_STEPS = 6'h2e;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_DIV = 1'b1
   } plz_state_t;
   typedef logic [PTS-1:0][VAL_W-1:0] plz_col_t;
endpackage

/* rtl/plz_chan_if.sv */
`timescale 1ns/10ps
interface plz_chan_if;
   import plz_pkg::*;
   logic [1:0] mode;
   plz_col_t tbl_x;
   plz_col_t tbl_y;
   logic in_valid;
   logic [VAL_W-1:0] in_value;
   logic in_ready;
   logic out_valid;
   logic [VAL_W-1:0] out_value;
   modport host (output mode, tbl_x, tbl_y, in_valid, in_value,
                 input in_ready, out_valid, out_value);
   modport chan (input mode, tbl_x, tbl_y, in_valid, in_value,
                 output in_ready, out_valid, out_value);
endinterface

/* rtl/plz_chan.sv */
`timescale 1ns/10ps
module plz_chan
#(
   parameter int N_PTS = plz_pkg::PTS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // channel link
   plz_chan_if.chan ch
);
   import plz_pkg::*;

   typedef struct packed {
      plz_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [EXT_W-1:0] rem;
      logic [EXT_W-1:0] den;
      logic [DIV_W-1:0] dvd;
      logic neg;
      logic mir;
      logic [EXT_W-1:0] base;
      logic ready;
      logic out_valid;
      logic [VAL_W-1:0] out_value;
   } plz_chan_s_t;

   plz_chan_s_t s_q, s_d;
   logic signed [EXT_W-1:0] xin, xe, xa, xb, ya, yb, x0, y0;
   logic signed [DIV_W-1:0] prod;
   logic [EXT_W:0] trial;
   logic [DIV_W-1:0] dvd_n;
   logic [3:0] seg, nxt;
   logic mir;

   // point search and index width are built for sixteen points only
   if (N_PTS != PTS)
   begin : g_bad_pts
      $error("plz_chan: table must hold exactly sixteen points");
   end

   function automatic logic signed [EXT_W-1:0] sx(input logic [VAL_W-1:0] v);
      sx = $signed({{(EXT_W-VAL_W){v[VAL_W-1]}}, v});
   endfunction

   function automatic logic [VAL_W-1:0] mirr(input logic signed [EXT_W-1:0] v,
                                           input logic m);
      logic signed [EXT_W-1:0] r;
      r = m ? -v : v;
      mirr = r[VAL_W-1:0];
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.out_valid = 1'b0;
      xin = sx(ch.in_value);
      mir = (ch.mode == MODE_MIRROR) && ch.in_value[VAL_W-1];
      xe = mir ? -xin : xin;
      // last point not above the input; needs ascending x
      seg = 4'h0;
      for (int i = 1; i < PTS; i++)
      begin
         if (xe >= sx(ch.tbl_x[i]))
            seg = 4'(i);
      end
      nxt = (seg == 4'hf) ? seg : seg + 4'h1;
      x0 = sx(ch.tbl_x[0]);
      y0 = sx(ch.tbl_y[0]);
      xa = sx(ch.tbl_x[seg]);
      xb = sx(ch.tbl_x[nxt]);
      ya = sx(ch.tbl_y[seg]);
      yb = sx(ch.tbl_y[nxt]);
      prod = (xe - xa) * (yb - ya);
      trial = {s_q.rem, s_q.dvd[DIV_W-1]};
      dvd_n = {s_q.dvd[DIV_W-2:0], 1'b0};
      case (s_q.st)
         ST_IDLE:
         begin
            if (ch.in_valid)
            begin
               s_d.out_valid = 1'b1;
               if (ch.mode != MODE_MIRROR && ch.mode != MODE_FULL)
                  s_d.out_value = ch.in_value;
               else if (xe <= x0)
                  s_d.out_value = mirr(y0, mir);
               else if (seg == 4'hf)
                  s_d.out_value = mirr(ya, mir);
               else if (xe == xa)
                  s_d.out_value = mirr(ya, mir);
               else
               begin
                  // table is snapshotted so rewrites do not tear a result
                  s_d.out_valid = 1'b0;
                  s_d.st = ST_DIV;
                  s_d.ready = 1'b0;
                  s_d.cnt = DIV_STEPS;
                  s_d.rem = '0;
                  s_d.den = xb - xa;
                  s_d.neg = prod[DIV_W-1];
                  s_d.dvd = prod[DIV_W-1] ? -prod : prod;
                  s_d.base = ya;
                  s_d.mir = mir;
               end
            end
         end
         ST_DIV:
         begin
            // restoring divide, one quotient bit per cycle
            if (trial >= {1'b0, s_q.den})
            begin
               s_d.rem = EXT_W'(trial - {1'b0, s_q.den});
               dvd_n[0] = 1'b1;
            end
            else
               s_d.rem = trial[EXT_W-1:0];
            s_d.dvd = dvd_n;
            s_d.cnt = s_q.cnt - 6'h01;
            if (s_q.cnt == 6'h01)
            begin
               s_d.st = ST_IDLE;
               s_d.ready = 1'b1;
               s_d.out_valid = 1'b1;
               s_d.out_value = mirr(s_q.base + (s_q.neg ?
                  -$signed(dvd_n[EXT_W-1:0]) :
                  $signed(dvd_n[EXT_W-1:0])), s_q.mir);
            end
         end
         default:
            s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.ready <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign ch.in_ready = s_q.ready;
   assign ch.out_valid = s_q.out_valid;
   assign ch.out_value = s_q.out_value;
endmodule

/* rtl/plz_top.sv */
`timescale 1ns/10ps
// Operation
// - mode zero passes the value unchanged
// - mode one mirrors negatives around zero
// - mode two applies table over signed range
// - per channel sixteen x and y pairs
// - exact x match outputs its y
// - between points interpolate linearly
// - entries hold full signed setting range
// - below first x output first y
// - above last x output last y
module plz_top
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [plz_pkg::ADDR_W-1:0] paddr,
   input wire logic [plz_pkg::DATA_W-1:0] pwdata,
   output logic pready,
   output logic [plz_pkg::DATA_W-1:0] prdata,
   output logic pslverr,
   // speed samples in, index 0 is channel 1
   input wire logic [1:0] in_valid,
   input wire logic [1:0][plz_pkg::VAL_W-1:0] in_value,
   output logic [1:0] in_ready,
   // corrected samples out
   output logic [1:0] out_valid,
   output logic [1:0][plz_pkg::VAL_W-1:0] out_value
);
   import plz_pkg::*;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
      logic [1:0][1:0] mode;
      logic [1:0][PTS-1:0][VAL_W-1:0] tx;
      logic [1:0][PTS-1:0][VAL_W-1:0] ty;
   } plz_top_s_t;

   plz_top_s_t s_q, s_d;
   logic hit_tbl, hit_mode, hit_stat, tch, tyl;
   logic [3:0] tpt;
   logic [DATA_W-1:0] rd;
   logic [1:0] busy;

   plz_chan_if ifc [2] ();

   for (genvar g = 0; g < 2; g++)
   begin : g_ch
      assign ifc[g].mode = s_q.mode[g];
      assign ifc[g].tbl_x = s_q.tx[g];
      assign ifc[g].tbl_y = s_q.ty[g];
      assign ifc[g].in_valid = in_valid[g];
      assign ifc[g].in_value = in_value[g];
      assign in_ready[g] = ifc[g].in_ready;
      assign busy[g] = ~ifc[g].in_ready;
      assign out_valid[g] = ifc[g].out_valid;
      assign out_value[g] = ifc[g].out_value;
      plz_chan #(.N_PTS(PTS)) u_chan
      (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .ch(ifc[g])
      );
   end

   always_comb
   begin
      s_d = s_q;
      tch = paddr[TBL_CH_BIT];
      tyl = paddr[TBL_Y_BIT];
      tpt = paddr[TBL_PT_MSB:TBL_PT_LSB];
      hit_tbl = (paddr[ADDR_W-1:8] == PAGE_TBL_CH1 ||
                 paddr[ADDR_W-1:8] == PAGE_TBL_CH2) &&
                !paddr[TBL_HOLE_BIT] && paddr[1:0] == 2'h0;
      hit_mode = 1'b0;
      hit_stat = 1'b0;
      rd = '0;
      if (paddr == OFS_MODE_CH1)
      begin
         hit_mode = 1'b1;
         rd[1:0] = s_q.mode[0];
      end
      else if (paddr == OFS_MODE_CH2)
      begin
         hit_mode = 1'b1;
         rd[1:0] = s_q.mode[1];
      end
      else if (paddr == OFS_STATUS)
      begin
         hit_stat = 1'b1;
         rd[1:0] = busy;
      end
      else if (hit_tbl)
         rd[VAL_W-1:0] = tyl ? s_q.ty[tch][tpt] : s_q.tx[tch][tpt];
      // one wait state keeps pready and prdata on flops
      s_d.pready = psel && penable && !s_q.pready;
      if (psel && penable && !s_q.pready)
      begin
         s_d.prdata = pwrite ? '0 : rd;
         s_d.pslverr = !(hit_mode || hit_stat || hit_tbl) ||
                       (pwrite && hit_stat);
      end
      if (psel && penable && s_q.pready && pwrite)
      begin
         // mode codes above two are refused, old mode stays
         if (hit_mode && pwdata[1:0] <= MODE_FULL)
            s_d.mode[paddr[2]] = pwdata[1:0];
         else if (hit_tbl && tyl)
            s_d.ty[tch][tpt] = pwdata[VAL_W-1:0];
         else if (hit_tbl)
            s_d.tx[tch][tpt] = pwdata[VAL_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.mode <= {2{MODE_RST}};
         s_q.tx <= {(2*PTS){TBL_RST}};
         s_q.ty <= {(2*PTS){TBL_RST}};
      end
      else
         s_q <= s_d;
   end

   assign pready = s_q.pready;
   assign prdata = s_q.prdata;
   assign pslverr = s_q.pslverr;
endmodule

/* tb/plz_top_monitor.sv */
`timescale 1ns/10ps
module plz_top_monitor
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // samples
   input wire logic [1:0] in_valid,
   input wire logic [1:0][20:0] in_value,
   input wire logic [1:0] in_ready,
   input wire logic [1:0] out_valid,
   input wire logic [1:0][20:0] out_value
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_direct(c);
      ##1 out_valid[c];
   endsequence
   // fixed divide span keeps results in order
   sequence s_interp(c);
      ##1 (!in_ready[c] && !out_valid[c]) [*8] ##39
         (out_valid[c] && in_ready[c]);
   endsequence
   a_ch1_answer: assert property (in_valid[0] && in_ready[0] |->
      (s_direct(0) or s_interp(0))) else $error("ch1 answer late");
   a_ch2_answer: assert property (in_valid[1] && in_ready[1] |->
      (s_direct(1) or s_interp(1))) else $error("ch2 answer late");
   a_ready_back: assert property ($rose(in_ready[0]) |->
      out_valid[0]) else $error("ch1 ready early");
   a_value_holds: assert property ($changed(out_value[0]) |->
      out_valid[0]) else $error("ch1 value moved");
   a_apb_wait: assert property (psel && penable && !pready |=>
      pready) else $error("apb wait wrong");
   a_ready_pulse: assert property (pready |=>
      !pready) else $error("pready long");
   a_read_zext: assert property (pready && !pwrite |->
      prdata[31:21] == 11'h0) else $error("read not extended");
   a_unmapped_err: assert property (pready && paddr[11:10] != 2'h0 |->
      pslverr) else $error("unmapped accepted");
endmodule

/* tb/plz_src.sv */
`timescale 1ns/10ps
module plz_src
(
   // clock
   input wire logic sys_clk,
   // samples out
   output logic [1:0] in_valid,
   output logic [1:0][plz_pkg::VAL_W-1:0] in_value,
   input wire logic [1:0] in_ready,
   // results in
   input wire logic [1:0] out_valid,
   input wire logic [1:0][plz_pkg::VAL_W-1:0] out_value
);
   import plz_pkg::*;
   initial {in_valid, in_value} = '0;
   task put(input int ch, gap, input logic [VAL_W-1:0] v,
      output logic [VAL_W-1:0] r);
      repeat (gap) @(posedge sys_clk);
      in_valid[ch] <= 1'b1;
      in_value[ch] <= v;
      do @(posedge sys_clk); while (in_ready[ch] !== 1'b1);
      in_valid[ch] <= 1'b0;
      // scrambled once released, stale data must not pass
      in_value[ch] <= ~v;
      do @(posedge sys_clk); while (out_valid[ch] !== 1'b1);
      r = out_value[ch];
   endtask
endmodule

/* tb/test_piecewise_linearizer.sv */
`timescale 1ns/10ps
module test_piecewise_linearizer;
   import plz_pkg::*;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdat;
   logic [1:0] in_valid, in_ready, out_valid;
   logic [1:0][VAL_W-1:0] in_value, out_value;
   logic [VAL_W-1:0] res;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   // channel, mode, sample, expected
   int tc [12][4] = '{'{0,2,-400,0}, '{0,2,700,1500}, '{0,2,-256,100},
      '{0,2,-250,109}, '{0,2,-70,390}, '{0,1,-70,-609}, '{0,1,-700,-1500},
      '{0,1,70,609}, '{1,2,70,-609}, '{1,2,-400,0}, '{1,0,70,70},
      '{0,0,-250,-250}};
   plz_top DUT (.*);
   plz_src src (.*);
   always #2.5 sys_clk = ~sys_clk;
   function logic [DATA_W-1:0] ze(input int v);
      return DATA_W'(v) & 32'h001fffff;
   endfunction
   task chk(input string nm, input logic [DATA_W-1:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [ADDR_W-1:0] a, input int d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= ze(d);
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [ADDR_W-1:0] a, input int e);
      apb(1'b0, a, 0);
      chk("prdata", ze(e), rdat);
   endtask
   task report_and_stop;
      error_cnt += int'(cyc >= 4000);
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk)
      if (++cyc == 4000)
         report_and_stop;
   initial
   begin
      {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(OFS_MODE_CH1, 0);
      rd(OFS_MODE_CH2, 0);
      rd(12'h17c, 0);
      apb(1'b1, 12'h200, -199999);
      rd(12'h200, -199999);
      apb(1'b1, 12'h27c, 999999);
      rd(12'h27c, 999999);
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, 12'h100 + 12'(8 * i), 64 * i - 320);
         apb(1'b1, 12'h104 + 12'(8 * i), 100 * i);
         apb(1'b1, 12'h200 + 12'(8 * i), 64 * i - 320);
         apb(1'b1, 12'h204 + 12'(8 * i), -100 * i);
      end
      rd(12'h27c, -1500);
      rd(12'h400, 0);
      chk("pslverr", 32'h1, rerr);
      apb(1'b1, OFS_MODE_CH2, 3);
      rd(OFS_MODE_CH2, 0);
      rd(OFS_STATUS, 0);
      apb(1'b1, OFS_STATUS, 3);
      chk("pslverr", 32'h1, rerr);
      for (int i = 0; i < 12; i++)
      begin
         apb(1'b1, tc[i][0] ? OFS_MODE_CH2 : OFS_MODE_CH1, tc[i][1]);
         src.put(tc[i][0], i % 2, VAL_W'(tc[i][2]), res);
         chk("out_value", ze(tc[i][3]), DATA_W'(res));
      end
      // status must show ch1 busy while its divide runs
      apb(1'b1, OFS_MODE_CH1, 2);
      fork
         src.put(0, 0, VAL_W'(-250), res);
         begin
            repeat (3) @(posedge sys_clk);
            rd(OFS_STATUS, 1);
         end
      join
      chk("out_value", ze(109), DATA_W'(res));
      rd(OFS_STATUS, 0);
      report_and_stop;
   end
endmodule
bind plz_top plz_top_monitor mon (.*);
